// File: itc_timer.v
// Summary of operation
// - mode 1: gate rise drives low, TC high
// - mode 1: new count waits next trigger
// - mode 1: gate rise retriggers from stored count
// - mode 2: one-clock low pulse at TC
// - mode 2: gate rise starts, gate low stops
// - mode 2: new count after next pulse
// - mode 3: square wave, decrement by two
// - mode 3 odd: first 1, then 3
// - mode 4: output high, count after load
// - mode 4: one-clock low pulse at zero
// - mode 4: reload applies next clock
// - mode 4: counts only while gate high
// - mode 5: gate rise starts, TC pulse low
// - mode 5: gate rise restarts stored count
// - transfer exactly the selected count bytes
// - zero count means 65536 or 10000
// - mode 0: first byte suspends counting
// - access code zero latches counter value
// - control byte: select, access, mode, BCD
// - access codes: latch, high, low, both
// - mode 0: low on load, high at zero
// - BCD bit selects decimal or binary
//
// The Avalon-MM slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "itc_timer_regs.vh"

module itc_timer #(
  parameter NUM_CH = 3
) (
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  output wire [31:0] avs_readdata,
  output wire avs_waitrequest,
  input wire [NUM_CH-1:0] tmr_clk,
  input wire [NUM_CH-1:0] tmr_gate,
  output wire [NUM_CH-1:0] tmr_out
);

  reg waitrequest_ff;
  reg [31:0] readdata_ff;
  wire req = avs_read | avs_write;
  wire ack = ce & req & ~waitrequest_ff;
  wire [1:0] idx = avs_address[`ITC_ADDR_IDX];
  wire [7:0] wbyte = avs_writedata[7:0];
  wire cw_fire = ack & avs_write & (idx == `ITC_IDX_CTRL);
  wire [8*NUM_CH-1:0] rd_bytes;
  wire [NUM_CH-1:0] out_bits;
  reg [7:0] nxt_rbyte;

  assign avs_readdata = readdata_ff;
  assign avs_waitrequest = waitrequest_ff;
  assign tmr_out = out_bits;

  // decimal-aware decrement by one
  function [15:0] dec1;
    input [15:0] v;
    input bcd;
    reg [15:0] r;
    reg brw;
    integer k;
    begin
      r = v;
      brw = 1'b1;
      if (!bcd)
      begin
        r = v - `ITC_CNT_ONE;
      end
      else
      begin
        for (k = 0; k < 4; k = k + 1)
        begin
          if (brw)
          begin
            if (v[k*4 +: 4] == `ITC_BCD_ZERO)
            begin
              r[k*4 +: 4] = `ITC_BCD_NINE;
            end
            else
            begin
              r[k*4 +: 4] = v[k*4 +: 4] - 4'h1;
              brw = 1'b0;
            end
          end
        end
      end
      dec1 = r;
    end
  endfunction

  // decrement by one to three steps; zero wraps to the maximum
  function [15:0] decn;
    input [15:0] v;
    input [1:0] step;
    input bcd;
    reg [15:0] r;
    integer j;
    begin
      r = v;
      for (j = 0; j < 3; j = j + 1)
      begin
        if (j < step)
        begin
          r = dec1(r, bcd);
        end
      end
      decn = r;
    end
  endfunction

  always @*
  begin
    nxt_rbyte = `ITC_BYTE_ZERO;
    if (idx == `ITC_IDX_CNT0)
    begin
      nxt_rbyte = rd_bytes[7:0];
    end
    else if (idx == `ITC_IDX_CNT1 && NUM_CH > 1)
    begin
      nxt_rbyte = rd_bytes[15:8];
    end
    else if (idx == `ITC_IDX_CNT2 && NUM_CH > 2)
    begin
      nxt_rbyte = rd_bytes[23:16];
    end
  end

  // one wait state, then a one-cycle acknowledge
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      waitrequest_ff <= 1'b1;
      readdata_ff <= `ITC_RDATA_ZERO;
    end
    else if (ce)
    begin
      if (req && waitrequest_ff)
      begin
        waitrequest_ff <= 1'b0;
        readdata_ff <= avs_read ? {`ITC_RDATA_PAD, nxt_rbyte} : `ITC_RDATA_ZERO;
      end
      else
      begin
        waitrequest_ff <= 1'b1;
      end
    end
  end

  genvar i;
  generate
    for (i = 0; i < NUM_CH; i = i + 1)
    begin : g_ch
      reg [2:0] mode_ff;
      reg [1:0] rw_ff;
      reg bcd_ff;
      reg [15:0] cnt_ff;
      reg [15:0] cr_ff;
      reg [15:0] latch_ff;
      reg lat_ff;
      reg out_ff;
      reg ld_ff;
      reg trg_ff;
      reg arm_ff;
      reg val_ff;
      reg hold_ff;
      reg fst_ff;
      reg wr_hi_ff;
      reg rd_hi_ff;
      reg clk_d_ff;
      reg gate_d_ff;
      wire tick = tmr_clk[i] & ~clk_d_ff;
      wire gate = tmr_gate[i];
      wire gate_rise = gate & ~gate_d_ff;
      wire wr_cw = cw_fire & (wbyte[`ITC_CW_SEL] == i);
      wire wr_cnt = ack & avs_write & (idx == i);
      wire rd_cnt = ack & avs_read & (idx == i);
      wire is_m2 = (mode_ff == `ITC_MODE_2) | (mode_ff == `ITC_MODE_2X);
      wire is_m3 = (mode_ff == `ITC_MODE_3) | (mode_ff == `ITC_MODE_3X);
      // odd count steps 1 then 3
      wire [1:0] step3 = (fst_ff & cnt_ff[0]) ? (out_ff ? `ITC_STEP_1 : `ITC_STEP_3) : `ITC_STEP_2;
      wire [15:0] dec_1 = decn(cnt_ff, `ITC_STEP_1, bcd_ff);
      wire [15:0] dec_3 = decn(cnt_ff, step3, bcd_ff);
      wire last_byte = (rw_ff != `ITC_RW_BOTH) | wr_hi_ff;
      wire [15:0] src = lat_ff ? latch_ff : cnt_ff;

      assign rd_bytes[i*8 +: 8] = (rw_ff == `ITC_RW_HI) ? src[15:8] :
                                  (rw_ff == `ITC_RW_LO) ? src[7:0] :
                                  (rw_ff == `ITC_RW_BOTH) ? (rd_hi_ff ? src[15:8] : src[7:0]) :
                                  `ITC_BYTE_ZERO;
      assign out_bits[i] = out_ff;

      always @(posedge clk_sys)
      begin
        if (!rst_n)
        begin
          mode_ff <= `ITC_MODE_0;
          rw_ff <= `ITC_RW_LATCH;
          bcd_ff <= 1'b0;
          cnt_ff <= `ITC_CNT_ZERO;
          cr_ff <= `ITC_CNT_ZERO;
          latch_ff <= `ITC_CNT_ZERO;
          lat_ff <= 1'b0;
          out_ff <= 1'b1;
          ld_ff <= 1'b0;
          trg_ff <= 1'b0;
          arm_ff <= 1'b0;
          val_ff <= 1'b0;
          hold_ff <= 1'b0;
          fst_ff <= 1'b0;
          wr_hi_ff <= 1'b0;
          rd_hi_ff <= 1'b0;
          clk_d_ff <= 1'b0;
          // idle-high gate gives no false edge after reset
          gate_d_ff <= 1'b1;
        end
        else if (ce)
        begin
          clk_d_ff <= tmr_clk[i];
          gate_d_ff <= gate;
          if (gate_rise)
          begin
            trg_ff <= 1'b1;
          end
          if (tick)
          begin
            trg_ff <= gate_rise;
            case (mode_ff)
              `ITC_MODE_0:
              begin
                if (ld_ff)
                begin
                  cnt_ff <= cr_ff;
                  ld_ff <= 1'b0;
                end
                else if (gate && !hold_ff)
                begin
                  cnt_ff <= dec_1;
                  if (cnt_ff == `ITC_CNT_ONE)
                  begin
                    out_ff <= 1'b1;
                  end
                end
              end
              `ITC_MODE_1:
              begin
                if (trg_ff && val_ff)
                begin
                  cnt_ff <= cr_ff;
                  out_ff <= 1'b0;
                  arm_ff <= 1'b1;
                end
                else
                begin
                  cnt_ff <= dec_1;
                  if (arm_ff && cnt_ff == `ITC_CNT_ONE)
                  begin
                    out_ff <= 1'b1;
                    arm_ff <= 1'b0;
                  end
                end
              end
              `ITC_MODE_4:
              begin
                if (!out_ff)
                begin
                  out_ff <= 1'b1;
                end
                if (ld_ff)
                begin
                  cnt_ff <= cr_ff;
                  ld_ff <= 1'b0;
                  arm_ff <= 1'b1;
                end
                else if (gate)
                begin
                  cnt_ff <= dec_1;
                  if (arm_ff && cnt_ff == `ITC_CNT_ONE)
                  begin
                    out_ff <= 1'b0;
                    arm_ff <= 1'b0;
                  end
                end
              end
              `ITC_MODE_5:
              begin
                if (trg_ff && val_ff)
                begin
                  cnt_ff <= cr_ff;
                  arm_ff <= 1'b1;
                  out_ff <= 1'b1;
                end
                else
                begin
                  cnt_ff <= dec_1;
                  if (arm_ff && cnt_ff == `ITC_CNT_ONE)
                  begin
                    out_ff <= 1'b0;
                    arm_ff <= 1'b0;
                  end
                  else
                  begin
                    out_ff <= 1'b1;
                  end
                end
              end
              default:
              begin
                if (!gate)
                begin
                  out_ff <= 1'b1;
                end
                else if ((ld_ff || trg_ff) && val_ff)
                begin
                  cnt_ff <= cr_ff;
                  out_ff <= 1'b1;
                  fst_ff <= 1'b1;
                  ld_ff <= 1'b0;
                end
                else if (is_m2)
                begin
                  // low for one clock at TC
                  if (cnt_ff == `ITC_CNT_ONE)
                  begin
                    cnt_ff <= cr_ff;
                    out_ff <= 1'b1;
                  end
                  else
                  begin
                    cnt_ff <= dec_1;
                    if (dec_1 == `ITC_CNT_ONE)
                    begin
                      out_ff <= 1'b0;
                    end
                  end
                end
                else if (is_m3)
                begin
                  if (cnt_ff == {14'h0000, step3})
                  begin
                    cnt_ff <= cr_ff;
                    out_ff <= ~out_ff;
                    fst_ff <= 1'b1;
                  end
                  else
                  begin
                    cnt_ff <= dec_3;
                    fst_ff <= 1'b0;
                  end
                end
              end
            endcase
          end
          if (wr_cw)
          begin
            if (wbyte[`ITC_CW_RW] == `ITC_RW_LATCH)
            begin
              if (!lat_ff)
              begin
                latch_ff <= cnt_ff;
                lat_ff <= 1'b1;
              end
            end
            else
            begin
              mode_ff <= wbyte[`ITC_CW_MODE];
              rw_ff <= wbyte[`ITC_CW_RW];
              bcd_ff <= wbyte[`ITC_CW_BCD];
              out_ff <= (wbyte[`ITC_CW_MODE] != `ITC_MODE_0);
              ld_ff <= 1'b0;
              arm_ff <= 1'b0;
              val_ff <= 1'b0;
              hold_ff <= 1'b0;
              wr_hi_ff <= 1'b0;
              rd_hi_ff <= 1'b0;
              lat_ff <= 1'b0;
            end
          end
          if (wr_cnt && rw_ff != `ITC_RW_LATCH)
          begin
            if (rw_ff == `ITC_RW_HI)
            begin
              cr_ff <= {wbyte, `ITC_BYTE_ZERO};
            end
            else if (rw_ff == `ITC_RW_LO || !wr_hi_ff)
            begin
              cr_ff[7:0] <= wbyte;
              if (rw_ff == `ITC_RW_LO)
              begin
                cr_ff[15:8] <= `ITC_BYTE_ZERO;
              end
            end
            else
            begin
              cr_ff[15:8] <= wbyte;
            end
            if (rw_ff == `ITC_RW_BOTH)
            begin
              wr_hi_ff <= ~wr_hi_ff;
            end
            hold_ff <= ~last_byte;
            if (last_byte)
            begin
              val_ff <= 1'b1;
              if (mode_ff == `ITC_MODE_0 || mode_ff == `ITC_MODE_4)
              begin
                ld_ff <= 1'b1;
              end
              else if ((is_m2 || is_m3) && !val_ff)
              begin
                ld_ff <= 1'b1;
              end
            end
            if (mode_ff == `ITC_MODE_0)
            begin
              out_ff <= 1'b0;
            end
          end
          if (rd_cnt && rw_ff != `ITC_RW_LATCH)
          begin
            if (rw_ff == `ITC_RW_BOTH)
            begin
              rd_hi_ff <= ~rd_hi_ff;
            end
            if (rw_ff != `ITC_RW_BOTH || rd_hi_ff)
            begin
              lat_ff <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

endmodule

// File: itc_timer_regs.vh
`ifndef ITC_TIMER_REGS_VH
`define ITC_TIMER_REGS_VH

// register indices, byte address is four times the index
`define ITC_IDX_CNT0 2'h0
`define ITC_IDX_CNT1 2'h1
`define ITC_IDX_CNT2 2'h2
`define ITC_IDX_CTRL 2'h3
`define ITC_ADDR_IDX 3:2

// control byte fields
`define ITC_CW_SEL 7:6
`define ITC_CW_RW 5:4
`define ITC_CW_MODE 3:1
`define ITC_CW_BCD 0

// byte-access codes
`define ITC_RW_LATCH 2'h0
`define ITC_RW_HI 2'h1
`define ITC_RW_LO 2'h2
`define ITC_RW_BOTH 2'h3

// counting modes
`define ITC_MODE_0 3'h0
`define ITC_MODE_1 3'h1
`define ITC_MODE_2 3'h2
`define ITC_MODE_3 3'h3
`define ITC_MODE_4 3'h4
`define ITC_MODE_5 3'h5
`define ITC_MODE_2X 3'h6
`define ITC_MODE_3X 3'h7

// counter constants
`define ITC_CNT_ONE 16'h0001
`define ITC_CNT_ZERO 16'h0000
`define ITC_STEP_1 2'h1
`define ITC_STEP_2 2'h2
`define ITC_STEP_3 2'h3
`define ITC_BCD_NINE 4'h9
`define ITC_BCD_ZERO 4'h0
`define ITC_BYTE_ZERO 8'h00
`define ITC_RDATA_PAD 24'h000000
`define ITC_RDATA_ZERO 32'h00000000

`endif

// File: itc_timer_properties.sv
`timescale 1ns/1ps
module itc_timer_props #(
  parameter NUM_CH = 3
) (
  input wire clk_sys,
  input wire rst_n,
  input wire ce,
  input wire [3:0] avs_address,
  input wire avs_read,
  input wire avs_write,
  input wire [31:0] avs_writedata,
  input wire [31:0] avs_readdata,
  input wire avs_waitrequest,
  input wire [NUM_CH-1:0] tmr_clk,
  input wire [NUM_CH-1:0] tmr_gate,
  input wire [NUM_CH-1:0] tmr_out
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  logic [NUM_CH-1:0] clk_q_ff;
  wire [NUM_CH-1:0] step_w = tmr_clk & ~clk_q_ff;
  wire any_step_w = |step_w;
  wire req_w = (avs_read || avs_write) && avs_waitrequest;
  wire req_any_w = avs_read || avs_write;
  // step history frozen with the design's own clock enable
  always @(posedge clk_sys)
  begin
    if (!rst_n)
      clk_q_ff <= {NUM_CH{1'b0}};
    else if (ce)
      clk_q_ff <= tmr_clk;
  end
  property p_ack_next;
    req_w && ce |=> !avs_waitrequest;
  endproperty
  a_ack_next: assert property (p_ack_next) else $error("no ack one cycle after request");
  property p_ack_pulse;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  property p_ack_cause;
    !avs_waitrequest |-> $past(req_any_w);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_pad;
    avs_readdata[31:8] == 24'h000000;
  endproperty
  a_pad: assert property (p_pad) else $error("read data upper bits not zero");
  property p_rdata_hold;
    !$stable(avs_readdata) |-> $past(req_w);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data changed without access");
  property p_out_cause;
    !$stable(tmr_out) |-> $past(any_step_w) || $past(!avs_waitrequest);
  endproperty
  a_out_cause: assert property (p_out_cause) else $error("output moved without step or write");
  property p_freeze;
    !ce |=> $stable(tmr_out) && $stable(avs_waitrequest);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while disabled");
  property p_reset_val;
    $rose(rst_n) |-> tmr_out == {NUM_CH{1'b1}} && avs_waitrequest;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("wrong state after reset");
  c_read: cover property (avs_read && !avs_waitrequest);
  c_out_fall: cover property ($fell(tmr_out[0]));
  c_out_rise: cover property ($rose(tmr_out[2]));
endmodule

bind itc_timer itc_timer_props #(.NUM_CH(NUM_CH)) itc_timer_props_inst (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .ce(ce),
  .avs_address(avs_address),
  .avs_read(avs_read),
  .avs_write(avs_write),
  .avs_writedata(avs_writedata),
  .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest),
  .tmr_clk(tmr_clk),
  .tmr_gate(tmr_gate),
  .tmr_out(tmr_out)
);

// File: itc_host_model.sv
`timescale 1ns/1ps
module itc_host_model (
  input wire clk_sys,
  input wire avs_waitrequest,
  input wire [31:0] avs_readdata,
  output logic [3:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata
);
  initial
  begin
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
  end
  task xfer(input logic wr, input logic [3:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    avs_read <= ~wr;
    avs_write <= wr;
    @(posedge clk_sys);
    while (avs_waitrequest)
      @(posedge clk_sys);
    q = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    avs_address <= ~a;
    avs_writedata <= ~avs_writedata;
  endtask
endmodule

// File: tb_itc_timer.sv
`timescale 1ns/1ps
module tb_itc_timer;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic [2:0] tmr_clk = 3'h0;
  logic [2:0] tmr_gate = 3'h7;
  wire [2:0] tmr_out;
  wire [3:0] avs_address;
  wire avs_read;
  wire avs_write;
  wire avs_waitrequest;
  wire [31:0] avs_writedata;
  wire [31:0] avs_readdata;
  int err_count = 0;
  int cmp_count = 0;
  int cyc = 0;
  logic [7:0] q;
  logic [15:0] pat;

  initial
  begin
    forever #5 clk_sys = ~clk_sys;
  end

  itc_timer #(.NUM_CH(3)) itc_timer_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .tmr_clk(tmr_clk), .tmr_gate(tmr_gate), .tmr_out(tmr_out)
  );
  itc_host_model itc_host_model_inst (
    .clk_sys(clk_sys), .avs_waitrequest(avs_waitrequest), .avs_readdata(avs_readdata),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata)
  );

  task stop_test;
  begin
    $display("compares %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask

  task chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
  begin
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  end
  endtask

  task chk_out(input string n, input logic [15:0] e, input logic [15:0] g);
  begin
    cmp_count++;
    if (g !== e)
    begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  end
  endtask

  task wr(input logic [3:0] a, input logic [7:0] d);
    itc_host_model_inst.xfer(1'b1, a, d, q);
  endtask

  task rd(input logic [3:0] a, input logic [7:0] e, input string n);
  begin
    itc_host_model_inst.xfer(1'b0, a, 8'h00, q);
    chk_byte(n, e, q);
  end
  endtask

  // count steps seen by all channels
  task step(input int n);
    repeat (n)
    begin
      @(posedge clk_sys);
      tmr_clk <= 3'h7;
      @(posedge clk_sys);
      tmr_clk <= 3'h0;
    end
  endtask

  task out_now(input int ch, input logic e, input string n);
  begin
    @(negedge clk_sys);
    chk_out(n, {15'h0000, e}, {15'h0000, tmr_out[ch]});
  end
  endtask

  task collect(input int ch, input int n, input logic [15:0] e, input string nm);
  begin
    pat = 16'h0000;
    repeat (n)
    begin
      step(1);
      @(negedge clk_sys);
      pat = {pat[14:0], tmr_out[ch]};
    end
    chk_out(nm, e, pat);
  end
  endtask

  task prog(input int ch, input logic [7:0] cw, input logic [7:0] cnt);
  begin
    wr(4'hC, cw);
    wr(ch[1:0] * 4, cnt);
  end
  endtask

  task trig(input int ch);
  begin
    @(posedge clk_sys);
    tmr_gate[ch] <= 1'b0;
    @(posedge clk_sys);
    tmr_gate[ch] <= 1'b1;
  end
  endtask

  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    if (cyc == 40000)
    begin
      err_count++;
      stop_test;
    end
  end

  initial
  begin
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    out_now(0, 1'b1, "out_after_reset");
    rd(4'hC, 8'h00, "ctrl_read");
    $display("test reset done");
    wr(4'hC, 8'h30);
    wr(4'h0, 8'h05);
    wr(4'h0, 8'h01);
    step(1);
    ce <= 1'b0;
    step(2);
    ce <= 1'b1;
    step(2);
    wr(4'hC, 8'h00);
    step(1);
    rd(4'h0, 8'h03, "latch_lo");
    rd(4'h0, 8'h01, "latch_hi");
    rd(4'h0, 8'h02, "direct_lo");
    rd(4'h0, 8'h01, "direct_hi");
    step(257);
    out_now(0, 1'b0, "m0_before_zero");
    step(1);
    out_now(0, 1'b1, "m0_at_zero");
    $display("test mode0 latch done");
    prog(1, 8'h64, 8'h03);
    step(1);
    collect(1, 6, 16'h002D, "m2_pulses");
    @(posedge clk_sys);
    tmr_gate[1] <= 1'b0;
    collect(1, 3, 16'h0007, "m2_gate_low");
    @(posedge clk_sys);
    tmr_gate[1] <= 1'b1;
    collect(1, 4, 16'h000D, "m2_gate_rise");
    prog(2, 8'hA6, 8'h05);
    step(1);
    collect(2, 10, 16'h0339, "m3_odd");
    prog(2, 8'hA6, 8'h04);
    step(1);
    collect(2, 8, 16'h0099, "m3_even");
    $display("test mode2 mode3 done");
    wr(4'hC, 8'h20);
    out_now(0, 1'b0, "m0_ctrl_low");
    wr(4'hC, 8'h28);
    out_now(0, 1'b1, "m4_ctrl_high");
    wr(4'h0, 8'h03);
    step(1);
    tmr_gate[0] <= 1'b0;
    collect(0, 4, 16'h000F, "m4_gate_low");
    @(posedge clk_sys);
    tmr_gate[0] <= 1'b1;
    collect(0, 5, 16'h001B, "m4_strobe");
    prog(0, 8'h18, 8'h01);
    step(1);
    wr(4'hC, 8'h00);
    rd(4'h0, 8'h01, "hi_latch");
    $display("test mode4 done");
    prog(1, 8'h62, 8'h02);
    trig(1);
    collect(1, 4, 16'h0003, "m1_shot");
    trig(1);
    collect(1, 4, 16'h0003, "m1_retrig");
    prog(2, 8'hAA, 8'h02);
    trig(2);
    collect(2, 4, 16'h000D, "m5_strobe");
    trig(2);
    collect(2, 4, 16'h000D, "m5_retrig");
    $display("test mode1 mode5 done");
    prog(2, 8'hA1, 8'h00);
    step(2);
    wr(4'hC, 8'h80);
    rd(4'h8, 8'h99, "bcd_latch");
    step(9998);
    out_now(2, 1'b0, "bcd_max_low");
    step(1);
    out_now(2, 1'b1, "bcd_max_high");
    $display("test bcd zero done");
    stop_test;
  end
endmodule
